// >>> design/lpmwk_pkg.sv
// package: constants, register map and types of the low power mode and wake-up controller
package lpmwk_pkg;
    // ==========================================================
    // sizes
    localparam int WAKE_NUM = 19;
    localparam int PIN_NUM = 16;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] ADDR_FSMR = 8'h00;
    localparam logic [7:0] ADDR_CLKCFG = 8'h04;
    localparam logic [7:0] ADDR_BKWAKE = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_WAKETIME = 8'h10;
    // ==========================================================
    // field positions
    localparam int FSMR_LPS_BIT = 20;
    localparam int CFG_OSC_BIT = 0;
    localparam int CFG_MASTER_PLL_BIT = 1;
    localparam int CFG_PLL_EN_BIT = 2;
    localparam int CFG_PCLK_SLEEP_BIT = 3;
    localparam int CFG_SRAM_KEEP_BIT = 4;
    localparam int STAT_FSU_BIT = 3;
    // ==========================================================
    // reset values
    localparam logic [18:0] FS_EN_RST = 19'h00000;
    localparam logic [18:0] BK_EN_RST = 19'h00000;
    localparam logic [4:0] CFG_RST = 5'h01; // fast rc running, master clock on it
    // ==========================================================
    // timing
    localparam int CLK_NS = 40;
    localparam int RC_START_NS = 2000;
    localparam int CORE_RST_NS = 1000;
    localparam logic [7:0] RC_START_CYC = 8'((RC_START_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] CORE_RST_CYC = 8'((CORE_RST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] RESYNC_CYC = 8'h03;
    // ==========================================================
    // types
    typedef enum logic [2:0] {
        ST_ACTIVE = 3'b000,
        ST_SLEEP = 3'b001,
        ST_WAIT_ENTER = 3'b010,
        ST_WAIT = 3'b011,
        ST_RC_START = 3'b100,
        ST_BACKUP = 3'b101,
        ST_BK_EXIT = 3'b110
    } lpmwk_state_t;
    typedef struct packed {
        logic core_clk;
        logic periph_clk;
        logic mem_clk;
        logic core_pwr;
        logic sram_pwr;
        logic regulator;
        logic fast_rc;
        logic master_on_pll;
        logic pll_en;
        logic core_rst;
    } lpmwk_ctl_t;
endpackage

// >>> design/lpmwk_fsu_detect.sv
// fast start-up detection: clockless combine of the enabled active-low wake inputs
`timescale 1ns/1ps
module lpmwk_fsu_detect #(
    parameter int N = 19
) (
    input wire logic [N-1:0] WAKE_N_IN,
    input wire logic [N-1:0] EN_IN,
    output logic REQ_OUT
);
    // pure gates, no clock needed, so it still works with all clocks stopped
    assign REQ_OUT = |(~WAKE_N_IN & EN_IN);
endmodule

// >>> design/lpmwk_sync.sv
// two-flop synchroniser for levels entering the system clock domain
`timescale 1ns/1ps
module lpmwk_sync #(
    parameter int W = 1
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic [W-1:0] DIN_IN,
    output logic [W-1:0] DOUT_OUT
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } lpmwk_sync_t;
    lpmwk_sync_t q, d;
    // first stage is read only by the second stage
    always_comb begin
        d.s1 = DIN_IN;
        d.s2 = q.s1;
    end
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign DOUT_OUT = q.s2;
endmodule

// >>> design/lpmwk_top.sv
// low power mode decode, clock and power gating and wake-up sequencing
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - sleep stops only core clock; peripheral clocks follow configuration
// - wait-for-interrupt or wait-for-event with both selects zero enters sleep
// - interrupt-entered sleep wakes on interrupt only; event-entered on interrupt or event
// - wake sources are configured one by one; of the power regions only sram has a setting of its own, for backup
// - backup wake re-enables core and sram supplies if off
// - low level on any enabled of 19 wake inputs starts fast wake
// - fast start detection is clockless and gives one request
// - request restarts fast rc, moves master clock to it, re-enables core clock
// - after wake from wait or backup the pll stays off; software restarts it
// - wake time is counted from wake event to first fetch
// - wait-for-event with deep sleep enters backup; regulator and core supply off
// - backup exits on enabled pin transition or alarm through core reset
// - wait mode stops core, peripheral and memory clocks, supplies stay on
// - wait entered by wait-for-event with low power select; exits on events
module lpmwk_top
    import lpmwk_pkg::*;
(
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [31:0] REG_RDATA_OUT,
    input wire logic WAIT_INT_INSTR_IN,
    input wire logic WAIT_EVT_INSTR_IN,
    input wire logic DEEP_SLEEP_IN,
    input wire logic IRQ_IN,
    input wire logic EVENT_IN,
    input wire logic [18:0] WAKE_N_IN,
    output lpmwk_ctl_t CTL_OUT,
    output logic [2:0] MODE_OUT
);
    typedef struct packed {
        lpmwk_state_t st;
        logic [7:0] cnt;
        logic by_event;
        logic [18:0] fs_en;
        logic lps;
        logic osc_en;
        logic master_on_pll;
        logic pll_en;
        logic pclk_sleep;
        logic sram_keep;
        logic [18:0] bk_en;
        logic [15:0] pins_q;
        logic timing;
        logic [15:0] wake_cnt;
        logic [15:0] wake_time;
        lpmwk_ctl_t ctl;
        logic [31:0] rdata;
    } lpmwk_core_t;

    lpmwk_core_t q, d;
    logic fsu_raw;
    logic fsu_sync;
    logic bk_wake;
    logic sleep_wake;
    logic wait_wake;

    // ==========================================================
    // fast start-up path
    lpmwk_fsu_detect #(
        .N(WAKE_NUM)
    ) u_detect (
        .WAKE_N_IN(WAKE_N_IN),
        .EN_IN(q.fs_en),
        .REQ_OUT(fsu_raw)
    );

    // the raw request is asynchronous to us; two flops before any decision
    lpmwk_sync #(
        .W(1)
    ) u_sync (
        .CLK_SYS_IN(CLK_SYS_IN),
        .RST_IN(RST_IN),
        .DIN_IN(fsu_raw),
        .DOUT_OUT(fsu_sync)
    );

    // ==========================================================
    // wake conditions
    // backup: enabled pin edges plus enabled alarm levels (supply monitor, calendar, timer)
    assign bk_wake = (|((WAKE_N_IN[15:0] ^ q.pins_q) & q.bk_en[15:0]))
                   | (|(~WAKE_N_IN[18:16] & q.bk_en[18:16]));
    // interrupt-entered sleep ignores events on purpose
    assign sleep_wake = IRQ_IN | (q.by_event & (EVENT_IN | fsu_sync));
    assign wait_wake = fsu_sync | EVENT_IN;

    // ==========================================================
    // next state
    always_comb begin
        d = q;
        d.rdata = 32'h0;
        d.pins_q = WAKE_N_IN[15:0];
        // software side
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                ADDR_FSMR: d.rdata = {11'h0, q.lps, 1'b0, q.fs_en};
                ADDR_CLKCFG: d.rdata = {27'h0, q.sram_keep, q.pclk_sleep, q.pll_en, q.master_on_pll, q.osc_en};
                ADDR_BKWAKE: d.rdata = {13'h0, q.bk_en};
                ADDR_STATUS: d.rdata = {28'h0, fsu_sync, q.st};
                ADDR_WAKETIME: d.rdata = {16'h0, q.wake_time};
                default: d.rdata = 32'h0;
            endcase
        end
        if (REG_WR_IN) begin
            case (REG_ADDR_IN)
                ADDR_FSMR: begin
                    d.fs_en = REG_WDATA_IN[18:0];
                    d.lps = REG_WDATA_IN[FSMR_LPS_BIT];
                end
                ADDR_CLKCFG: begin
                    d.osc_en = REG_WDATA_IN[CFG_OSC_BIT];
                    d.master_on_pll = REG_WDATA_IN[CFG_MASTER_PLL_BIT];
                    d.pll_en = REG_WDATA_IN[CFG_PLL_EN_BIT];
                    d.pclk_sleep = REG_WDATA_IN[CFG_PCLK_SLEEP_BIT];
                    d.sram_keep = REG_WDATA_IN[CFG_SRAM_KEEP_BIT];
                end
                ADDR_BKWAKE: d.bk_en = REG_WDATA_IN[18:0];
                default: ;
            endcase
        end
        // wake timer runs from the wake event to the first fetch
        if (q.timing && q.wake_cnt != 16'hffff) begin
            d.wake_cnt = q.wake_cnt + 16'h0001;
        end
        // mode sequencing; placed after writes so hardware updates win
        case (q.st)
            ST_ACTIVE: begin
                if (WAIT_EVT_INSTR_IN && DEEP_SLEEP_IN) begin
                    d.st = ST_BACKUP;
                    d.pll_en = 1'b0;
                    d.master_on_pll = 1'b0;
                    d.osc_en = 1'b0;
                end else if (WAIT_EVT_INSTR_IN && q.lps) begin
                    // oscillator enable and clocks drop now; wait state follows after resync
                    d.st = ST_WAIT_ENTER;
                    d.cnt = RESYNC_CYC;
                    d.osc_en = 1'b0;
                    d.pll_en = 1'b0;
                end else if (WAIT_INT_INSTR_IN || WAIT_EVT_INSTR_IN) begin
                    d.st = ST_SLEEP;
                    d.by_event = WAIT_EVT_INSTR_IN;
                end
            end
            ST_SLEEP: begin
                if (sleep_wake) begin
                    d.st = ST_ACTIVE;
                    d.wake_time = 16'h0001;
                end
            end
            ST_WAIT_ENTER: begin
                d.cnt = q.cnt - 8'h01;
                if (q.cnt == 8'h01) begin
                    d.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (wait_wake) begin
                    d.st = ST_RC_START;
                    d.cnt = RC_START_CYC;
                    d.osc_en = 1'b1;
                    d.timing = 1'b1;
                    d.wake_cnt = 16'h0000;
                end
            end
            ST_RC_START: begin
                d.cnt = q.cnt - 8'h01;
                if (q.cnt == 8'h01) begin
                    // master clock back on fast rc; pll left for software
                    d.st = ST_ACTIVE;
                    d.master_on_pll = 1'b0;
                    d.timing = 1'b0;
                    d.wake_time = q.wake_cnt + 16'h0001;
                end
            end
            ST_BACKUP: begin
                if (bk_wake) begin
                    d.st = ST_BK_EXIT;
                    d.cnt = CORE_RST_CYC;
                    d.osc_en = 1'b1;
                    d.timing = 1'b1;
                    d.wake_cnt = 16'h0000;
                end
            end
            ST_BK_EXIT: begin
                d.cnt = q.cnt - 8'h01;
                if (q.cnt == 8'h01) begin
                    d.st = ST_ACTIVE;
                    d.timing = 1'b0;
                    d.wake_time = q.wake_cnt + 16'h0001;
                end
            end
            default: d.st = ST_ACTIVE;
        endcase
        // ======================================================
        // gating outputs, decoded from the next mode so they are registered
        d.ctl = '{core_clk: 1'b1, periph_clk: 1'b1, mem_clk: 1'b1, core_pwr: 1'b1,
                  sram_pwr: 1'b1, regulator: 1'b1, fast_rc: d.osc_en, master_on_pll: d.master_on_pll,
                  pll_en: d.pll_en, core_rst: 1'b0};
        case (d.st)
            ST_SLEEP: begin
                d.ctl.core_clk = 1'b0;
                d.ctl.periph_clk = d.pclk_sleep;
            end
            ST_WAIT_ENTER, ST_WAIT, ST_RC_START: begin
                d.ctl.core_clk = 1'b0;
                d.ctl.periph_clk = 1'b0;
                d.ctl.mem_clk = 1'b0;
            end
            ST_BACKUP: begin
                d.ctl.core_clk = 1'b0;
                d.ctl.periph_clk = 1'b0;
                d.ctl.mem_clk = 1'b0;
                d.ctl.core_pwr = 1'b0;
                d.ctl.regulator = 1'b0;
                d.ctl.sram_pwr = d.sram_keep;
            end
            ST_BK_EXIT: begin
                d.ctl.core_rst = 1'b1;
            end
            default: ;
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            q <= '0;
            q.st <= ST_ACTIVE;
            q.fs_en <= FS_EN_RST;
            q.bk_en <= BK_EN_RST;
            q.osc_en <= CFG_RST[CFG_OSC_BIT];
            q.pins_q <= 16'hffff; // idle pins sit high
            q.ctl <= '{core_clk: 1'b1, periph_clk: 1'b1, mem_clk: 1'b1, core_pwr: 1'b1,
                       sram_pwr: 1'b1, regulator: 1'b1, fast_rc: 1'b1, master_on_pll: 1'b0,
                       pll_en: 1'b0, core_rst: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign REG_RDATA_OUT = q.rdata;
    assign CTL_OUT = q.ctl;
    assign MODE_OUT = q.st;

    // ==========================================================
    // assertions
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);

    a_sleep_entry: assert property ((q.st == ST_ACTIVE) && WAIT_INT_INSTR_IN && !WAIT_EVT_INSTR_IN
        |=> (q.st == ST_SLEEP) && !CTL_OUT.core_clk && CTL_OUT.mem_clk)
        else $error("sleep not entered on wait for interrupt");
    a_backup_prio: assert property ((q.st == ST_ACTIVE) && WAIT_EVT_INSTR_IN && DEEP_SLEEP_IN
        |=> (q.st == ST_BACKUP) && !CTL_OUT.core_pwr && !CTL_OUT.regulator)
        else $error("deep sleep did not select backup");
    a_wait_decode: assert property ((q.st == ST_ACTIVE) && WAIT_EVT_INSTR_IN && !DEEP_SLEEP_IN && q.lps
        |=> (q.st == ST_WAIT_ENTER) ##3 (q.st == ST_WAIT))
        else $error("wait entry sequence wrong");
    a_wait_osc_off: assert property ((q.st == ST_ACTIVE) && WAIT_EVT_INSTR_IN && !DEEP_SLEEP_IN && q.lps
        |=> !q.osc_en && !CTL_OUT.fast_rc)
        else $error("oscillator enable not cleared on wait entry");
    a_wait_clocks: assert property ((q.st == ST_WAIT)
        |-> !CTL_OUT.core_clk && !CTL_OUT.periph_clk && !CTL_OUT.mem_clk && CTL_OUT.core_pwr)
        else $error("clocks running or supply off in wait");
    a_sleep_periph: assert property ((q.st == ST_SLEEP)
        |-> CTL_OUT.core_pwr && CTL_OUT.mem_clk && (CTL_OUT.periph_clk == q.pclk_sleep))
        else $error("sleep gated more than the core clock");
    a_irq_sleep_holds: assert property ((q.st == ST_SLEEP) && !q.by_event && !IRQ_IN
        |=> (q.st == ST_SLEEP))
        else $error("interrupt sleep left without interrupt");
    a_rc_restart: assert property ((q.st == ST_WAIT) && fsu_sync
        |=> (q.st == ST_RC_START) && CTL_OUT.fast_rc
        ##[1:60] (q.st == ST_ACTIVE) && CTL_OUT.core_clk && !CTL_OUT.master_on_pll)
        else $error("fast start did not restart rc and core clock");
    a_bk_supply: assert property ((q.st == ST_BACKUP) && bk_wake
        |=> CTL_OUT.core_pwr && CTL_OUT.sram_pwr && CTL_OUT.core_rst)
        else $error("backup wake did not restore supplies");
    a_backup_sram: assert property ((q.st == ST_BACKUP) |-> (CTL_OUT.sram_pwr == q.sram_keep))
        else $error("sram supply ignores its backup setting");
    a_bk_exit_rst: assert property ((q.st == ST_BK_EXIT) |-> CTL_OUT.core_rst && CTL_OUT.core_pwr)
        else $error("backup exit not through core reset");
    a_sync_delay: assert property (fsu_sync == $past(fsu_raw, 2))
        else $error("fast start request not two flops late");
    a_pll_off: assert property ((q.st == ST_RC_START) ##1 (q.st == ST_ACTIVE)
        |-> !CTL_OUT.pll_en)
        else $error("pll restarted by hardware");

    // main scenarios the bench is expected to reach
    c_sleep_event_wake: cover property ((q.st == ST_SLEEP) && q.by_event ##1 (q.st == ST_ACTIVE));
    c_wait_entry: cover property ((q.st == ST_WAIT_ENTER) ##1 (q.st == ST_WAIT));
    c_wait_wake: cover property ((q.st == ST_RC_START) ##1 (q.st == ST_ACTIVE));
    c_backup_exit: cover property ((q.st == ST_BK_EXIT) ##1 (q.st == ST_ACTIVE));
endmodule

// >>> sim/lpmwk_core_model.sv
// processor core model: issues the wait instructions and holds the deep sleep select
`timescale 1ns/1ps
module lpmwk_core_model (
    input wire logic clk_in,
    output logic wait_int_out,
    output logic wait_evt_out,
    output logic deep_sleep_out
);
    // ==========================================================
    // idle core
    initial begin
        wait_int_out = 1'b0;
        wait_evt_out = 1'b0;
        deep_sleep_out = 1'b0;
    end
    // ==========================================================
    // one-cycle wait instruction; the select stays held like the core's own control bit
    // callers leave a cycle between calls so no strobe is assigned twice in one step
    task automatic exec_wait(input logic use_event, input logic deep);
        @(posedge clk_in);
        deep_sleep_out <= deep;
        wait_evt_out <= use_event;
        wait_int_out <= ~use_event;
        @(posedge clk_in);
        wait_evt_out <= 1'b0;
        wait_int_out <= 1'b0;
    endtask
endmodule

// >>> sim/testbench.sv
// self-checking testbench of the low power mode and wake-up controller
`timescale 1ns/1ps
module testbench;
    import lpmwk_pkg::*;
    logic clk, rst, wr, rd, wait_int, wait_evt, ds, irq, evt;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, rv;
    logic [18:0] wake_n;
    lpmwk_ctl_t ctl;
    logic [2:0] mode;
    int failures, check_count;
    // ==========================================================
    // clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    lpmwk_top lpmwk_top_inst (.CLK_SYS_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .WAIT_INT_INSTR_IN(wait_int),
        .WAIT_EVT_INSTR_IN(wait_evt), .DEEP_SLEEP_IN(ds), .IRQ_IN(irq), .EVENT_IN(evt), .WAKE_N_IN(wake_n),
        .CTL_OUT(ctl),
        .MODE_OUT(mode));
    lpmwk_core_model lpmwk_core_model_inst (.clk_in(clk), .wait_int_out(wait_int), .wait_evt_out(wait_evt),
        .deep_sleep_out(ds));
    // ==========================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe, so it is taken just past that edge
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // bounded wait for a mode code, sampled away from the edge
    task automatic wait_mode(input lpmwk_state_t m);
        repeat (200) if (mode !== m) @(negedge clk);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==========================================================
    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk);
        failures++;
        close_out();
    end
    // ==========================================================
    // test sequence
    initial begin
        rst = 1'b1;
        {addr, wdata, wr, rd, irq, evt} = '0;
        wake_n = '1;
        failures = 0;
        check_count = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset state and registers, plus an unmapped place
        check(32'(mode), 32'(ST_ACTIVE));
        check(32'(ctl), 32'h3f8);
        reg_rd(ADDR_CLKCFG, rv);
        check(rv, 32'(CFG_RST));
        reg_wr(8'h20, 32'hffffffff);
        reg_rd(8'h20, rv);
        check(rv, 32'h0);
        // sleep by wait-for-interrupt: an event must not wake it, an interrupt must
        lpmwk_core_model_inst.exec_wait(1'b0, 1'b0);
        wait_mode(ST_SLEEP);
        check(32'(mode), 32'(ST_SLEEP));
        check(32'(ctl), 32'h0f8);
        @(posedge clk) evt <= 1'b1;
        repeat (6) @(posedge clk);
        check(32'(mode), 32'(ST_SLEEP));
        evt <= 1'b0;
        irq <= 1'b1;
        wait_mode(ST_ACTIVE);
        check(32'(mode), 32'(ST_ACTIVE));
        @(posedge clk) irq <= 1'b0;
        reg_rd(ADDR_WAKETIME, rv);
        check(rv, 32'h1);
        // sleep by wait-for-event with peripheral clock kept, woken by an event
        reg_wr(ADDR_CLKCFG, 32'h09);
        lpmwk_core_model_inst.exec_wait(1'b1, 1'b0);
        wait_mode(ST_SLEEP);
        check(32'(ctl), 32'h1f8);
        @(posedge clk) evt <= 1'b1;
        wait_mode(ST_ACTIVE);
        check(32'(mode), 32'(ST_ACTIVE));
        @(posedge clk) evt <= 1'b0;
        // wait mode: fast rc as main clock, low power select and pin 0 enabled, then wait-for-event
        reg_wr(ADDR_CLKCFG, 32'h01);
        reg_wr(ADDR_FSMR, 32'h100001);
        reg_rd(ADDR_FSMR, rv);
        check(rv, 32'h100001);
        lpmwk_core_model_inst.exec_wait(1'b1, 1'b0);
        wait_mode(ST_WAIT_ENTER);
        check(32'(mode), 32'(ST_WAIT_ENTER));
        repeat (10) begin
            reg_rd(ADDR_CLKCFG, rv);
            if (rv[0] === 1'b0) break;
        end
        check(32'(rv[0]), 32'h0);
        wait_mode(ST_WAIT);
        check(32'(ctl), 32'h070);
        reg_rd(ADDR_STATUS, rv);
        check(rv, 32'h3);
        // a pin that is not enabled leaves the block asleep
        @(posedge clk) wake_n[1] <= 1'b0;
        repeat (8) @(posedge clk);
        check(32'(mode), 32'(ST_WAIT));
        wake_n[1] <= 1'b1;
        wake_n[0] <= 1'b0;
        wait_mode(ST_RC_START);
        check(32'(mode), 32'(ST_RC_START));
        check(32'(ctl.fast_rc), 32'h1);
        @(posedge clk) wake_n[0] <= 1'b1;
        wait_mode(ST_ACTIVE);
        check(32'(ctl), 32'h3f8);
        reg_wr(ADDR_CLKCFG, 32'h05);
        @(negedge clk);
        check(32'(ctl.pll_en), 32'h1);
        // backup: deep sleep outranks low power select; sram kept, pin 2 wakes
        reg_wr(ADDR_BKWAKE, 32'h4);
        reg_wr(ADDR_CLKCFG, 32'h11);
        lpmwk_core_model_inst.exec_wait(1'b1, 1'b1);
        wait_mode(ST_BACKUP);
        check(32'(mode), 32'(ST_BACKUP));
        check(32'({ctl.core_clk, ctl.core_pwr, ctl.regulator, ctl.sram_pwr}), 32'h1);
        @(posedge clk) wake_n[3] <= 1'b0;
        repeat (6) @(posedge clk);
        check(32'(mode), 32'(ST_BACKUP));
        wake_n[2] <= 1'b0;
        wait_mode(ST_BK_EXIT);
        check(32'(mode), 32'(ST_BK_EXIT));
        check(32'({ctl.core_rst, ctl.core_pwr, ctl.sram_pwr}), 32'h7);
        wait_mode(ST_ACTIVE);
        check(32'(ctl.core_rst), 32'h0);
        close_out();
    end
endmodule
